// >>> logic/cpu_stall_unit.sv
// Pipeline interlock, extra-state timing and system configuration registers.
`timescale 1ns/10ps
`default_nettype none
module cpu_stall_unit (
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic        ISSUE,
    input  wire logic        I_SFR_RD,
    input  wire logic        I_SFR_WR,
    input  wire logic        I_PSW_RD,
    input  wire logic        I_PSW_WR,
    input  wire logic        I_FLAGS_UPD,
    input  wire logic        I_SP_WR,
    input  wire logic        I_SP_STEP,
    input  wire logic        I_COND_BRANCH,
    input  wire logic        I_EXT_RD,
    input  wire logic        I_EXT_WR,
    input  wire logic        I_WORD,
    input  wire logic        I_JUMP,
    input  wire logic        I_CACHE_JUMP,
    input  wire logic        I_TARGET_DW,
    input  wire logic        I_NEXT_DW,
    input  wire logic [3:0]  I_TARGET_ADDR,
    input  wire logic [3:0]  I_NEXT_ADDR,
    input  wire logic [15:0] SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic        SFR_RD,
    input  wire logic        SFR_BYTE,
    input  wire logic [15:0] SFR_WDATA,
    input  wire logic        HW_PSW_WE,
    input  wire logic [15:0] HW_PSW_VAL,
    input  wire logic        HW_SP_WE,
    input  wire logic [15:0] HW_SP_VAL,
    input  wire logic        HW_MDC_WE,
    input  wire logic [15:0] HW_MDC_VAL,
    input  wire logic        STRAP_BUS_ACTIVE,
    input  wire logic [1:0]  STRAP_BUS_TYPE,
    output logic             ISSUE_READY,
    output logic             INSTR_DONE,
    output logic [4:0]       EXTRA_STATES,
    output logic             EXT_BUSY,
    output logic [15:0]      SFR_RDATA,
    output logic [15:0]      PSW_VALUE,
    output logic [15:0]      SP_VALUE,
    output logic [15:0]      MDC_VALUE,
    output logic [1:0]       STACK_SIZE_SEL,
    output logic             READY_INPUT_EN,
    output logic             SEGMENT_ADDR_EN,
    output logic             BYTE_HIGH_EN,
    output logic             SYS_CLOCK_OUT,
    output logic             SYS_CLOCK_OE,
    output logic [1:0]       BUS_TYPE,
    output logic             BUS_ACTIVE,
    output logic             TRISTATE_CTRL,
    output logic             RW_DELAY_CTRL,
    output logic [3:0]       MEM_CYCLE_CTRL
);
    typedef struct packed {
        stall_pkg::stall_state_t state;
        logic [4:0]              ctr;
        logic [4:0]              extra;
        logic [1:0]              act_rd;
        logic [1:0]              act_wr;
        logic                    start;
        logic                    prev_sfr_wr;
        logic                    prev_flags;
        logic                    prev_sp_wr;
        logic                    prev_psw_wr;
        logic [15:0]             system_configuration;
        logic [2:0][15:0]        core;
        logic [15:0]             rdata;
        logic [2:0]              sync1;
        logic [2:0]              sync2;
        logic [2:0]              sync3;
        logic                    strapped;
        logic [1:0]              settle;
        logic                    clk_out;
    } unit_t;

    unit_t unit_reg;
    unit_t unit_next;

    logic             tick;
    logic             phase;
    logic             timer_busy;
    logic             accept;
    logic             bus8;
    logic             muxed;
    logic [15:0]      waddr;
    logic [15:0]      wval;
    logic [4:0]       extra;
    logic [1:0]       n_act;
    logic [2:0]       hw_we;
    logic [2:0][15:0] hw_val;
    logic [2:0][15:0] core_next;

    state_divider u_div (
        .clk   (MCLK),
        .nrst  (NRST),
        .tick  (tick),
        .phase (phase)
    );

    ext_access_timer u_tmr (
        .clk   (MCLK),
        .nrst  (NRST),
        .tick  (tick),
        .start (unit_reg.start),
        .memory_cycle_time_control  (unit_reg.system_configuration[stall_pkg::MEMORY_CYCLE_TIME_CONTROL_LSB +: 4]),
        .tristate_time_control  (unit_reg.system_configuration[stall_pkg::TRISTATE_TIME_CONTROL_BIT]),
        .muxed (muxed),
        .busy  (timer_busy)
    );

    assign accept = ISSUE && ISSUE_READY;
    assign bus8   = (BUS_TYPE == stall_pkg::BUS_TYPE_SELECT_8_NONMUX) || (BUS_TYPE == stall_pkg::BUS_TYPE_SELECT_8_MUX);
    assign muxed  = (BUS_TYPE == stall_pkg::BUS_TYPE_SELECT_8_MUX) || (BUS_TYPE == stall_pkg::BUS_TYPE_SELECT_16_MUX);
    assign n_act  = (I_WORD && bus8) ? stall_pkg::TWO_ACT : stall_pkg::ONE_ACT;
    assign waddr  = {SFR_ADDR[15:1], 1'b0};

    // Byte writes land in the addressed half and zero the other half.
    always_comb begin
        if (!SFR_BYTE) begin
            wval = SFR_WDATA;
        end else if (SFR_ADDR[0]) begin
            wval = {SFR_WDATA[7:0], stall_pkg::ZERO_BYTE};
        end else begin
            wval = {stall_pkg::ZERO_BYTE, SFR_WDATA[7:0]};
        end
    end

    // Only the previous instruction's flags are held, so a gap clears every hazard.
    always_comb begin
        extra = 5'h00;
        if (I_SFR_RD && unit_reg.prev_sfr_wr) begin
            extra = extra + stall_pkg::SFR_HAZ_STATES;
        end
        if (I_PSW_RD && unit_reg.prev_flags) begin
            extra = extra + stall_pkg::PSW_HAZ_STATES;
        end
        if (I_SP_STEP && unit_reg.prev_sp_wr) begin
            extra = extra + stall_pkg::SP_HAZ_STATES;
        end
        if (I_COND_BRANCH && unit_reg.prev_psw_wr) begin
            extra = extra + stall_pkg::BR_HAZ_STATES;
        end
        if (I_JUMP) begin
            extra = extra + stall_pkg::JUMP_STATES;
            if (I_TARGET_DW && I_TARGET_ADDR[1]) begin
                extra = extra + stall_pkg::MISALIGN_STATES;
            end
        end else if (I_CACHE_JUMP) begin
            extra = extra + stall_pkg::CACHE_STATES;
            if (I_TARGET_DW && I_TARGET_ADDR[1] && I_NEXT_DW && I_NEXT_ADDR[1]) begin
                extra = extra + stall_pkg::MISALIGN_STATES;
            end
        end
    end

    assign hw_we  = {HW_SP_WE, HW_PSW_WE, HW_MDC_WE};
    assign hw_val = {HW_SP_VAL, HW_PSW_VAL, HW_MDC_VAL};

    genvar gi;
    generate
        for (gi = 0; gi < stall_pkg::NUM_CORE; gi = gi + 1) begin : g_core
            always_comb begin
                if (SFR_WR && waddr == stall_pkg::CORE_ADDRS[gi]) begin
                    core_next[gi] = wval;
                end else if (hw_we[gi]) begin
                    core_next[gi] = hw_val[gi];
                end else begin
                    core_next[gi] = unit_reg.core[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        unit_next = unit_reg;
        unit_next.start = 1'b0;
        unit_next.core = core_next;
        unit_next.sync1 = {STRAP_BUS_ACTIVE, STRAP_BUS_TYPE};
        unit_next.sync2 = unit_reg.sync1;
        unit_next.sync3 = unit_reg.sync2;
        unit_next.clk_out = unit_reg.system_configuration[stall_pkg::CLOCK_OUTPUT_ENABLE_BIT] && !phase;

        // Straps load the bus fields once, after they settle past reset.
        // The stages all read zero right after reset, so agreement only counts
        // once the pins have had time to reach the third stage.
        if (!(&unit_reg.settle)) begin
            unit_next.settle = unit_reg.settle + 2'h1;
        end
        if (!unit_reg.strapped && (&unit_reg.settle) && unit_reg.sync2 == unit_reg.sync3) begin
            unit_next.strapped = 1'b1;
            unit_next.system_configuration[stall_pkg::EXTERNAL_BUS_ACTIVE_BIT] = unit_reg.sync3[2];
            unit_next.system_configuration[stall_pkg::BUS_TYPE_SELECT_LSB +: 2] = unit_reg.sync3[1:0];
        end
        if (SFR_WR && waddr == stall_pkg::SYSTEM_CONFIGURATION_ADDR) begin
            unit_next.system_configuration = wval & stall_pkg::SYSTEM_CONFIGURATION_MASK;
        end

        if (SFR_RD) begin
            if (waddr == stall_pkg::SYSTEM_CONFIGURATION_ADDR) begin
                unit_next.rdata = unit_reg.system_configuration & stall_pkg::SYSTEM_CONFIGURATION_MASK;
            end else if (waddr == stall_pkg::MDC_ADDR) begin
                unit_next.rdata = unit_reg.core[0];
            end else if (waddr == stall_pkg::PSW_ADDR) begin
                unit_next.rdata = unit_reg.core[1];
            end else if (waddr == stall_pkg::SP_ADDR) begin
                unit_next.rdata = unit_reg.core[2];
            end else begin
                unit_next.rdata = stall_pkg::ZERO_WORD;
            end
        end

        case (unit_reg.state)
            stall_pkg::ST_IDLE: begin
                if (ISSUE) begin
                    unit_next.prev_sfr_wr = I_SFR_WR;
                    unit_next.prev_flags = I_FLAGS_UPD;
                    unit_next.prev_sp_wr = I_SP_WR;
                    unit_next.prev_psw_wr = I_PSW_WR;
                    unit_next.extra = extra;
                    unit_next.ctr = extra;
                    unit_next.act_rd = I_EXT_RD ? n_act : 2'h0;
                    unit_next.act_wr = I_EXT_WR ? n_act : 2'h0;
                    unit_next.state = (extra != 5'h00) ? stall_pkg::ST_INT : stall_pkg::ST_ACC;
                end
            end
            stall_pkg::ST_INT: begin
                if (tick) begin
                    unit_next.ctr = unit_reg.ctr - 5'h01;
                    if (unit_reg.ctr == 5'h01) begin
                        unit_next.state = stall_pkg::ST_ACC;
                    end
                end
            end
            stall_pkg::ST_ACC: begin
                // A read waits for its data; the last write is left to run alone.
                if (!timer_busy) begin
                    if (unit_reg.act_rd != 2'h0) begin
                        unit_next.start = 1'b1;
                        unit_next.act_rd = unit_reg.act_rd - 2'h1;
                    end else if (unit_reg.act_wr != 2'h0) begin
                        unit_next.start = 1'b1;
                        unit_next.act_wr = unit_reg.act_wr - 2'h1;
                        if (unit_reg.act_wr == 2'h1) begin
                            unit_next.state = stall_pkg::ST_DONE;
                        end
                    end else begin
                        unit_next.state = stall_pkg::ST_DONE;
                    end
                end
            end
            stall_pkg::ST_DONE: begin
                unit_next.state = stall_pkg::ST_IDLE;
            end
            default: begin
                unit_next.state = stall_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            unit_reg <= '0;
            unit_reg.system_configuration <= stall_pkg::SYSTEM_CONFIGURATION_RESET;
            unit_reg.core <= {stall_pkg::CORE_RESET, stall_pkg::CORE_RESET, stall_pkg::CORE_RESET};
        end else begin
            unit_reg <= unit_next;
        end
    end

    assign ISSUE_READY     = (unit_reg.state == stall_pkg::ST_IDLE);
    assign INSTR_DONE      = (unit_reg.state == stall_pkg::ST_DONE);
    assign EXTRA_STATES    = unit_reg.extra;
    assign EXT_BUSY        = timer_busy;
    assign SFR_RDATA       = unit_reg.rdata;
    assign MDC_VALUE       = unit_reg.core[0];
    assign PSW_VALUE       = unit_reg.core[1];
    assign SP_VALUE        = unit_reg.core[2];
    assign STACK_SIZE_SEL  = unit_reg.system_configuration[stall_pkg::STACK_SIZE_SELECT_LSB +: 2];
    assign READY_INPUT_EN  = unit_reg.system_configuration[stall_pkg::READY_INPUT_ENABLE_BIT];
    assign SEGMENT_ADDR_EN = !unit_reg.system_configuration[stall_pkg::SEGMENTATION_DISABLE_BIT];
    assign BYTE_HIGH_EN    = !unit_reg.system_configuration[stall_pkg::BYTE_HIGH_DISABLE_BIT];
    assign SYS_CLOCK_OUT   = unit_reg.clk_out;
    assign SYS_CLOCK_OE    = unit_reg.system_configuration[stall_pkg::CLOCK_OUTPUT_ENABLE_BIT];
    assign BUS_TYPE        = unit_reg.system_configuration[stall_pkg::BUS_TYPE_SELECT_LSB +: 2];
    assign BUS_ACTIVE      = unit_reg.system_configuration[stall_pkg::EXTERNAL_BUS_ACTIVE_BIT];
    assign TRISTATE_CTRL   = unit_reg.system_configuration[stall_pkg::TRISTATE_TIME_CONTROL_BIT];
    assign RW_DELAY_CTRL   = unit_reg.system_configuration[stall_pkg::READ_WRITE_DELAY_CONTROL_BIT];
    assign MEM_CYCLE_CTRL  = unit_reg.system_configuration[stall_pkg::MEMORY_CYCLE_TIME_CONTROL_LSB +: 4];

    // Helper term for the checks: an instruction with no conditional branch, jump or cache jump cost.
    logic no_br_jmp;
    assign no_br_jmp = !I_COND_BRANCH && !I_JUMP && !I_CACHE_JUMP;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    a_sfr_read_stall: assert property (accept && I_SFR_RD && unit_reg.prev_sfr_wr
        && !I_PSW_RD && !I_SP_STEP && no_br_jmp |=> EXTRA_STATES == 5'h01)
        else $error("SPECIAL_FUNCTION_REGISTER read after SPECIAL_FUNCTION_REGISTER write not stalled one state");
    a_psw_read_stall: assert property (accept && I_PSW_RD && unit_reg.prev_flags
        && !I_SFR_RD && !I_SP_STEP && no_br_jmp |=> EXTRA_STATES == 5'h02)
        else $error("status read after flag update not stalled two states");
    a_sp_step_stall: assert property (accept && I_SP_STEP && unit_reg.prev_sp_wr
        && !I_SFR_RD && !I_PSW_RD && no_br_jmp |=> EXTRA_STATES == 5'h02)
        else $error("stack step after stack write not stalled two states");
    a_branch_test_stall: assert property (accept && I_COND_BRANCH && unit_reg.prev_psw_wr
        && !I_SFR_RD && !I_PSW_RD && !I_SP_STEP && !I_JUMP && !I_CACHE_JUMP
        |=> EXTRA_STATES == 5'h01)
        else $error("branch after status write not one extra state");
    a_jump_aligned: assert property (accept && I_JUMP && !I_TARGET_ADDR[1] && !I_SFR_RD
        && !I_PSW_RD && !I_SP_STEP && !I_COND_BRANCH |=> EXTRA_STATES == 5'h04)
        else $error("aligned jump not four states");
    a_jump_misaligned: assert property (accept && I_JUMP && I_TARGET_DW && I_TARGET_ADDR[1]
        && !I_SFR_RD && !I_PSW_RD && !I_SP_STEP && !I_COND_BRANCH |=> EXTRA_STATES == 5'h06)
        else $error("misaligned jump target not six states");
    a_cache_jump_time: assert property (accept && I_CACHE_JUMP && !I_JUMP && !I_SFR_RD
        && !I_PSW_RD && !I_SP_STEP && !I_COND_BRANCH && !I_NEXT_DW |=> EXTRA_STATES == 5'h02)
        else $error("cache jump not two states");
    a_no_gap_hazard: assert property (accept && I_SFR_RD && !unit_reg.prev_sfr_wr
        && !I_PSW_RD && !I_SP_STEP && no_br_jmp |=> EXTRA_STATES == 5'h00)
        else $error("SPECIAL_FUNCTION_REGISTER read stalled without a preceding SPECIAL_FUNCTION_REGISTER write");
    a_sw_wins: assert property (SFR_WR && !SFR_BYTE && waddr == stall_pkg::PSW_ADDR
        && HW_PSW_WE |=> PSW_VALUE == $past(SFR_WDATA))
        else $error("hardware update beat software write");
    a_byte_clear: assert property (SFR_WR && SFR_BYTE && SFR_ADDR[0]
        && waddr == stall_pkg::SP_ADDR |=> SP_VALUE[7:0] == 8'h00)
        else $error("byte write left other byte");
    a_reserved_zero: assert property (SFR_RD && waddr == stall_pkg::SYSTEM_CONFIGURATION_ADDR
        |=> !SFR_RDATA[15])
        else $error("reserved bit read as one");
    a_reset_timing: assert property ($rose(NRST) |-> MEM_CYCLE_CTRL == 4'h0
        && !TRISTATE_CTRL && !RW_DELAY_CTRL)
        else $error("timing fields not cleared by reset");
    a_write_posted: assert property (unit_reg.state == stall_pkg::ST_ACC && !timer_busy
        && unit_reg.act_rd == 2'h0 && unit_reg.act_wr == 2'h1 |=> INSTR_DONE)
        else $error("last external write held the core");

    c_sfr_stall: cover property (accept && I_SFR_RD && unit_reg.prev_sfr_wr);
    c_ext_read: cover property (accept && I_EXT_RD ##[1:200] INSTR_DONE);
    c_misaligned: cover property (accept && I_JUMP && I_TARGET_DW && I_TARGET_ADDR[1]);
endmodule
`default_nettype wire

// >>> pkg/stall_pkg.sv
// Shared constants and types for the core stall and system configuration logic.
package stall_pkg;
    // Special function register word addresses.
    localparam logic [15:0] SYSTEM_CONFIGURATION_ADDR  = 16'hFF0C;
    localparam logic [15:0] MDC_ADDR     = 16'hFF0E;
    localparam logic [15:0] PSW_ADDR     = 16'hFF10;
    localparam logic [15:0] SP_ADDR      = 16'hFF12;
    localparam logic [15:0] SYSTEM_CONFIGURATION_MASK  = 16'h7FFF;
    localparam logic [15:0] SYSTEM_CONFIGURATION_RESET = 16'h0000;
    localparam logic [15:0] CORE_RESET   = 16'h0000;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;

    // Core registers that hardware may also update, indexed 0 to 2.
    localparam int unsigned NUM_CORE = 3;
    localparam logic [2:0][15:0] CORE_ADDRS = {SP_ADDR, PSW_ADDR, MDC_ADDR};

    // Configuration register field positions.
    localparam int unsigned STACK_SIZE_SELECT_LSB  = 13;
    localparam int unsigned READY_INPUT_ENABLE_BIT  = 12;
    localparam int unsigned SEGMENTATION_DISABLE_BIT = 11;
    localparam int unsigned EXTERNAL_BUS_ACTIVE_BIT = 10;
    localparam int unsigned BYTE_HIGH_DISABLE_BIT = 9;
    localparam int unsigned CLOCK_OUTPUT_ENABLE_BIT  = 8;
    localparam int unsigned BUS_TYPE_SELECT_LSB   = 6;
    localparam int unsigned TRISTATE_TIME_CONTROL_BIT   = 5;
    localparam int unsigned READ_WRITE_DELAY_CONTROL_BIT   = 4;
    localparam int unsigned MEMORY_CYCLE_TIME_CONTROL_LSB   = 0;

    // Bus type encodings.
    localparam logic [1:0] BUS_TYPE_SELECT_8_NONMUX  = 2'h0;
    localparam logic [1:0] BUS_TYPE_SELECT_8_MUX     = 2'h1;
    localparam logic [1:0] BUS_TYPE_SELECT_16_MUX    = 2'h2;
    localparam logic [1:0] BUS_TYPE_SELECT_16_NONMUX = 2'h3;

    // Costs in states, and access counts.
    localparam logic [4:0] SFR_HAZ_STATES  = 5'h01;
    localparam logic [4:0] PSW_HAZ_STATES  = 5'h02;
    localparam logic [4:0] SP_HAZ_STATES   = 5'h02;
    localparam logic [4:0] BR_HAZ_STATES   = 5'h01;
    localparam logic [4:0] JUMP_STATES     = 5'h04;
    localparam logic [4:0] CACHE_STATES    = 5'h02;
    localparam logic [4:0] MISALIGN_STATES = 5'h02;
    localparam logic [4:0] ACT_BASE_NONMUX = 5'h02;
    localparam logic [4:0] ACT_BASE_MUX    = 5'h03;
    localparam logic [4:0] MEMORY_CYCLE_TIME_CONTROL_MAX        = 5'h0F;
    localparam logic [4:0] TRISTATE_TIME_CONTROL_MAX        = 5'h01;
    localparam logic [1:0] ONE_ACT         = 2'h1;
    localparam logic [1:0] TWO_ACT         = 2'h2;

    // One state is two oscillator periods.
    localparam int unsigned OSC_PERIOD_NS = 100;
    localparam int unsigned STATE_NS      = 2 * OSC_PERIOD_NS;
    localparam int unsigned STATE_CYCLES  = STATE_NS / OSC_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INT  = 2'b01,
        ST_ACC  = 2'b10,
        ST_DONE = 2'b11
    } stall_state_t;
endpackage

// >>> logic/state_divider.sv
// State-rate enable generator: one tick per state.
`timescale 1ns/10ps
`default_nettype none
module state_divider (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      tick,
    output logic      phase
);
    typedef struct packed {
        logic phase;
    } div_t;

    div_t div_reg;
    div_t div_next;

    always_comb begin
        div_next = div_reg;
        div_next.phase = (32'(div_reg.phase) == stall_pkg::STATE_CYCLES - 1) ? 1'b0 : 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick  = (32'(div_reg.phase) == stall_pkg::STATE_CYCLES - 1);
    assign phase = div_reg.phase;
endmodule
`default_nettype wire

// >>> logic/ext_access_timer.sv
// Counts out one external access cycle in states.
`timescale 1ns/10ps
`default_nettype none
module ext_access_timer (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       tick,
    input  wire logic       start,
    input  wire logic [3:0] memory_cycle_time_control,
    input  wire logic       tristate_time_control,
    input  wire logic       muxed,
    output logic            busy
);
    typedef struct packed {
        logic [4:0] cnt;
    } tmr_t;

    tmr_t tmr_reg;
    tmr_t tmr_next;
    logic [4:0] length;

    // Base states, plus the programmed wait states and tri-state extension.
    assign length = (muxed ? stall_pkg::ACT_BASE_MUX : stall_pkg::ACT_BASE_NONMUX)
                  + (stall_pkg::MEMORY_CYCLE_TIME_CONTROL_MAX - {1'b0, memory_cycle_time_control})
                  + (stall_pkg::TRISTATE_TIME_CONTROL_MAX - {4'h0, tristate_time_control});

    always_comb begin
        tmr_next = tmr_reg;
        if (start) begin
            tmr_next.cnt = length;
        end else if (tick && tmr_reg.cnt != 5'h00) begin
            tmr_next.cnt = tmr_reg.cnt - 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    // Busy already in the cycle of the start so that no second access can slip in.
    assign busy = start || (tmr_reg.cnt != 5'h00);
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the stall unit and the system configuration register.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    wire         I_SFR_RD, I_SFR_WR, I_PSW_RD, I_PSW_WR, I_FLAGS_UPD, I_SP_WR, I_SP_STEP;
    wire         I_COND_BRANCH, I_EXT_RD, I_EXT_WR, I_WORD, I_JUMP, I_CACHE_JUMP;
    wire         I_TARGET_DW, I_NEXT_DW;
    logic        MCLK, NRST, ISSUE, SFR_WR, SFR_RD, SFR_BYTE, HW_PSW_WE, HW_SP_WE, HW_MDC_WE;
    logic        STRAP_BUS_ACTIVE, ISSUE_READY, INSTR_DONE, EXT_BUSY, READY_INPUT_EN;
    logic        SEGMENT_ADDR_EN, BYTE_HIGH_EN, SYS_CLOCK_OUT, SYS_CLOCK_OE, BUS_ACTIVE;
    logic        TRISTATE_CTRL, RW_DELAY_CTRL;
    logic [1:0]  STRAP_BUS_TYPE, STACK_SIZE_SEL, BUS_TYPE;
    logic [3:0]  I_TARGET_ADDR, I_NEXT_ADDR, MEM_CYCLE_CTRL;
    logic [4:0]  EXTRA_STATES;
    logic [14:0] desc;
    logic [15:0] SFR_ADDR, SFR_WDATA, HW_PSW_VAL, HW_SP_VAL, HW_MDC_VAL, SFR_RDATA;
    logic [15:0] PSW_VALUE, SP_VALUE, MDC_VALUE, w;
    int          errors, checked, cyc, seed, bsy, len;
    logic        done_busy;

    assign {I_SFR_RD, I_SFR_WR, I_PSW_RD, I_PSW_WR, I_FLAGS_UPD, I_SP_WR, I_SP_STEP, I_COND_BRANCH,
            I_EXT_RD, I_EXT_WR, I_WORD, I_JUMP, I_CACHE_JUMP, I_TARGET_DW, I_NEXT_DW} = desc;

    cpu_stall_unit cpu_stall_unit_inst (.*);

    always #50 MCLK = ~MCLK;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Entered and left at a falling edge; the descriptor is held until the accepting edge passed.
    task automatic issue(input logic [14:0] f, input logic [3:0] ta, na, input logic [4:0] exp);
        while (ISSUE_READY !== 1'b1) @(negedge MCLK);
        bsy = 0;
        {ISSUE, desc, I_TARGET_ADDR, I_NEXT_ADDR} = {1'b1, f, ta, na};
        @(negedge MCLK);
        ISSUE = 1'b0;
        while (INSTR_DONE !== 1'b1) @(negedge MCLK);
        done_busy = EXT_BUSY;
        chk({11'h000, EXTRA_STATES}, {11'h000, exp});
        @(negedge MCLK);
    endtask

    task automatic sfr_wr(input logic [15:0] a, d, input logic b, input logic [2:0] hw);
        {SFR_ADDR, SFR_WDATA, SFR_BYTE, SFR_WR} = {a, d, b, 1'b1};
        {HW_PSW_WE, HW_SP_WE, HW_MDC_WE} = hw;
        {HW_PSW_VAL, HW_SP_VAL, HW_MDC_VAL} = {3{~d}};
        @(negedge MCLK);
        {SFR_WR, HW_PSW_WE, HW_SP_WE, HW_MDC_WE} = 4'h0;
    endtask

    task automatic sfr_rd(input logic [15:0] a, input logic [15:0] exp);
        {SFR_ADDR, SFR_RD} = {a, 1'b1};
        @(negedge MCLK);
        SFR_RD = 1'b0;
        chk(SFR_RDATA, exp);
    endtask

    function automatic logic [4:0] jump_cost(input logic c, tdw, ndw, input logic [3:0] ta, na);
        if (!c) return stall_pkg::JUMP_STATES + ((tdw && ta[1]) ? stall_pkg::MISALIGN_STATES : 5'h00);
        return stall_pkg::CACHE_STATES + ((tdw && ndw && ta[1] && na[1]) ? stall_pkg::MISALIGN_STATES : 5'h00);
    endfunction

    // One access cycle of len states keeps the timer busy 2*len or 2*len+1 clocks.
    function automatic int act_len(input logic [3:0] m, input logic t, input logic mx);
        return int'(mx ? stall_pkg::ACT_BASE_MUX : stall_pkg::ACT_BASE_NONMUX)
            + int'(stall_pkg::MEMORY_CYCLE_TIME_CONTROL_MAX) - int'(m) + int'(stall_pkg::TRISTATE_TIME_CONTROL_MAX) - int'(t);
    endfunction

    always @(negedge MCLK) begin
        if (EXT_BUSY === 1'b1) bsy++;
    end

    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        {MCLK, NRST, ISSUE, SFR_WR, SFR_RD, SFR_BYTE, HW_PSW_WE, HW_SP_WE, HW_MDC_WE} = 9'h000;
        {SFR_ADDR, SFR_WDATA, HW_PSW_VAL, HW_SP_VAL, HW_MDC_VAL} = '0;
        {I_TARGET_ADDR, I_NEXT_ADDR, desc} = '0;
        {STRAP_BUS_ACTIVE, STRAP_BUS_TYPE, seed} = {1'b1, 2'h2, 32'h4};
        repeat (3) @(posedge MCLK);
        @(negedge MCLK);
        NRST = 1'b1;
        repeat (10) @(negedge MCLK);
        chk({7'h00, BUS_ACTIVE, BUS_TYPE, TRISTATE_CTRL, RW_DELAY_CTRL, MEM_CYCLE_CTRL}, 16'h0180);
        chk({14'h0000, SEGMENT_ADDR_EN, BYTE_HIGH_EN}, 16'h0003);
        sfr_rd(stall_pkg::SYSTEM_CONFIGURATION_ADDR, 16'h0480);
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'hFFFF : 16'($random(seed));
            sfr_wr(stall_pkg::SYSTEM_CONFIGURATION_ADDR, w, 1'b0, 3'h0);
            sfr_rd(stall_pkg::SYSTEM_CONFIGURATION_ADDR, w & stall_pkg::SYSTEM_CONFIGURATION_MASK);
            chk({14'h0000, STACK_SIZE_SEL}, {14'h0000, w[14:13]});
            chk({12'h000, READY_INPUT_EN, SEGMENT_ADDR_EN, BYTE_HIGH_EN, SYS_CLOCK_OE},
                {12'h000, w[12], ~w[11], ~w[9], w[8]});
            chk({7'h00, BUS_ACTIVE, BUS_TYPE, TRISTATE_CTRL, RW_DELAY_CTRL, MEM_CYCLE_CTRL},
                {7'h00, w[10], w[7:0]});
            if (!w[8]) chk({15'h0000, SYS_CLOCK_OUT}, 16'h0000);
        end
        sfr_wr(stall_pkg::SYSTEM_CONFIGURATION_ADDR | 16'h0001, 16'h00A5, 1'b1, 3'h0);
        sfr_rd(stall_pkg::SYSTEM_CONFIGURATION_ADDR, 16'h2500);
        sfr_wr(stall_pkg::SYSTEM_CONFIGURATION_ADDR, 16'h003C, 1'b1, 3'h0);
        sfr_rd(stall_pkg::SYSTEM_CONFIGURATION_ADDR, 16'h003C);
        sfr_wr(stall_pkg::PSW_ADDR, 16'h1234, 1'b0, 3'h4);
        chk(PSW_VALUE, 16'h1234);
        sfr_wr(16'h0000, 16'h0F0F, 1'b0, 3'h3);
        chk(SP_VALUE, 16'hF0F0);
        chk(MDC_VALUE, 16'hF0F0);
        sfr_rd(16'h0000, 16'h0000);
        $display("test registers finished");
        issue(15'h0000, 4'h0, 4'h0, 5'h00);
        issue(15'h2000, 4'h0, 4'h0, 5'h00);
        issue(15'h4000, 4'h0, 4'h0, stall_pkg::SFR_HAZ_STATES);
        issue(15'h2000, 4'h0, 4'h0, 5'h00);
        issue(15'h0000, 4'h0, 4'h0, 5'h00);
        issue(15'h4000, 4'h0, 4'h0, 5'h00);
        issue(15'h0400, 4'h0, 4'h0, 5'h00);
        issue(15'h1000, 4'h0, 4'h0, stall_pkg::PSW_HAZ_STATES);
        issue(15'h0200, 4'h0, 4'h0, 5'h00);
        issue(15'h0100, 4'h0, 4'h0, stall_pkg::SP_HAZ_STATES);
        issue(15'h0800, 4'h0, 4'h0, 5'h00);
        issue(15'h0080, 4'h0, 4'h0, stall_pkg::BR_HAZ_STATES);
        issue(15'h0080, 4'h0, 4'h0, 5'h00);
        $display("test hazards finished");
        issue(15'h000A, 4'hE, 4'h0, 5'h06);
        issue(15'h0008, 4'h2, 4'h0, 5'h04);
        issue(15'h0007, 4'hA, 4'hE, 5'h04);
        issue(15'h0007, 4'hA, 4'hC, 5'h02);
        for (int i = 0; i < 16; i++) begin
            w = 16'($random(seed));
            issue({11'h000, ~w[0], w[0], w[1], w[2]}, w[7:4], w[11:8],
                  jump_cost(w[0], w[1], w[2], w[7:4], w[11:8]));
        end
        $display("test jumps finished");
        sfr_wr(stall_pkg::SYSTEM_CONFIGURATION_ADDR, 16'h04AE, 1'b0, 3'h0);
        len = act_len(4'hE, 1'b1, 1'b1);
        issue(15'h0040, 4'h0, 4'h0, 5'h00);
        chk({15'h0000, bsy >= 2 * len && bsy <= 2 * len + 1}, 16'h0001);
        chk({15'h0000, done_busy}, 16'h0000);
        sfr_wr(stall_pkg::SYSTEM_CONFIGURATION_ADDR, 16'h042E, 1'b0, 3'h0);
        len = act_len(4'hE, 1'b1, 1'b0);
        issue(15'h0050, 4'h0, 4'h0, 5'h00);
        chk({15'h0000, bsy >= 4 * len && bsy <= 4 * len + 2}, 16'h0001);
        issue(15'h0040, 4'h0, 4'h0, 5'h00);
        chk({15'h0000, bsy >= 2 * len && bsy <= 2 * len + 1}, 16'h0001);
        issue(15'h0030, 4'h0, 4'h0, 5'h00);
        chk({15'h0000, done_busy}, 16'h0001);
        while (EXT_BUSY !== 1'b0) @(negedge MCLK);
        $display("test external finished");
        tally_and_finish();
    end
endmodule
`default_nettype wire
